//--- src/rtr_peak_hold.sv
// Peak-hold register for one receive channel strength code
`timescale 1ns/1ns
module rtr_peak_hold (
  input  logic     pclk,
  input  logic     presetn,
  rtr_peak_if.hold pk
);
  import rtr_pkg::*;

  logic [CODE_W-1:0] peak_q;

  // A sample in the clearing cycle starts the new peak, so it is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_q <= STR_RESET;
    end else if (pk.clear) begin
      peak_q <= pk.valid ? pk.code : STR_RESET;
    end else if (pk.valid && (pk.code > peak_q)) begin
      peak_q <= pk.code;
    end
  end

  assign pk.peak = peak_q;

  chk_peak_hold_still: assert property (@(posedge pclk) disable iff (!presetn)
    (!pk.clear && !(pk.valid && pk.code > peak_q)) |=> $stable(peak_q))
    else $error("peak changed without a larger code");
  chk_peak_rise_new: assert property (@(posedge pclk) disable iff (!presetn)
    (!pk.clear && pk.valid && pk.code > peak_q) |=> (peak_q == $past(pk.code)))
    else $error("larger code not captured");
  chk_peak_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pk.clear && !pk.valid) |=> (peak_q == STR_RESET))
    else $error("peak not cleared");

endmodule // rtr_peak_hold

//--- src/rtr_peak_if.sv
// Carrier between the bank and one peak-hold channel
`timescale 1ns/1ns
interface rtr_peak_if;
  logic       clear;
  logic       valid;
  logic [3:0] code;
  logic [3:0] peak;
  modport src  (output clear, output valid, output code, input peak);
  modport hold (input clear, input valid, input code, output peak);
endinterface

//--- src/rtr_pkg.sv
// Constants, field layout and types of the regulator, timer and strength register bank
package rtr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned CODE_W = 4;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h2a;
  localparam logic [7:0] IDX_DISP = 8'h2b;
  localparam logic [7:0] IDX_STR  = 8'h2c;
  localparam logic [7:0] IDX_AUX  = 8'h30;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DISP = {IDX_DISP[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STR  = {IDX_STR[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_AUX  = {IDX_AUX[5:0], 2'h0};

  // Control register fields
  localparam int unsigned CTRL_MODE_BIT          = 7;
  localparam int unsigned CTRL_CODE_HI           = 6;
  localparam int unsigned CTRL_CODE_LO           = 3;
  localparam int unsigned MEASURED_SUPPLY_SEL_HI = 2;
  localparam int unsigned MEASURED_SUPPLY_SEL_LO = 1;
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [REG_W-1:0] CTRL_WMASK = 8'hfe;

  // Display register fields
  localparam int unsigned DISP_CODE_HI = 7;
  localparam int unsigned DISP_CODE_LO = 4;
  localparam int unsigned DISP_GPT_BIT = 2;
  localparam int unsigned DISP_NRT_BIT = 1;
  localparam int unsigned DISP_MRT_BIT = 0;

  // Strength register fields
  localparam int unsigned AM_PEAK_STRENGTH_MSB = 7;
  localparam int unsigned PM_PEAK_STRENGTH_MSB = 3;
  localparam logic [CODE_W-1:0] STR_RESET = 4'h0;

  localparam int unsigned AUX_CHAN_BIT = 7;

  // Regulator codes: top code is the highest voltage, lowest legal code is 0101
  localparam logic [CODE_W-1:0] REG_CODE_MAX = 4'hf;
  localparam logic [CODE_W-1:0] REG_CODE_MIN = 4'h5;

  typedef enum logic [1:0] {
    SUP_MAIN    = 2'h0,
    SUP_ANALOG  = 2'h1,
    SUP_DIGITAL = 2'h2,
    SUP_RF      = 2'h3
  } rtr_supply_t;

  function automatic logic [3:0] rtr_supply_onehot(input rtr_supply_t s);
    return 4'h1 << s;
  endfunction

endpackage

//--- src/rtr_reg_sel.sv
// Chooses the regulator code in effect from adjust result or written code
`timescale 1ns/1ns
module rtr_reg_sel (
  input  logic                       pclk,
  input  logic                       presetn,
  input  logic                       set_default,
  input  logic                       manual_mode,
  input  logic [rtr_pkg::CODE_W-1:0] manual_code,
  input  logic                       adjust_valid,
  input  logic [rtr_pkg::CODE_W-1:0] adjust_code,
  output logic [rtr_pkg::CODE_W-1:0] eff_code,
  output logic                       code_legal
);
  import rtr_pkg::*;

  logic [CODE_W-1:0] adj_q;
  logic [CODE_W-1:0] eff_q;
  logic              legal_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adj_q <= REG_CODE_MAX;
    end else if (set_default) begin
      adj_q <= REG_CODE_MAX;
    end else if (adjust_valid) begin
      adj_q <= adjust_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_q <= REG_CODE_MAX;
    end else if (set_default) begin
      eff_q <= REG_CODE_MAX;
    end else begin
      eff_q <= manual_mode ? manual_code : adj_q;
    end
  end

  // Codes below the lowest step select no defined voltage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      legal_q <= 1'b1;
    end else begin
      legal_q <= (set_default || manual_mode) ? (set_default || manual_code >= REG_CODE_MIN)
                                              : (adj_q >= REG_CODE_MIN);
    end
  end

  assign eff_code   = eff_q;
  assign code_legal = legal_q;

  chk_adjust_path: assert property (@(posedge pclk) disable iff (!presetn)
    (!manual_mode && !set_default) |=> (eff_q == $past(adj_q)))
    else $error("adjust result not in effect");
  chk_code_legal: assert property (@(posedge pclk) disable iff (!presetn)
    (eff_q == REG_CODE_MAX) |-> legal_q)
    else $error("top code flagged unused");

endmodule // rtr_reg_sel

//--- src/rtr_regs.sv
// APB register bank for regulator control, timer display and peak signal strength
//
// What this block does
// - Mode bit picks adjust result or written code
// - Code 1111 highest, steps down to 0101
// - Two-bit field picks supply to measure
// - Control fields reset to zero, also on default
// - Display upper nibble shows code in effect
// - Reset and default select maximum voltage code
// - Display bit 2 shows general timer running
// - Display bit 1 shows no-response timer running
// - Display bit 0 shows mask-receive timer running
// - Upper nibble holds largest AM strength code
// - Lower nibble holds largest PM strength code
// - Peaks clear at message start and command
// - Strength register zero at reset, and at default unless a sample arrives in that cycle
// - Auxiliary bit 7 shows channel used internally
// - Strength code rises monotonically with level
// - Channel bit reads 0 AM, 1 PM
`timescale 1ns/1ns
module rtr_regs (
  input  logic                       pclk,
  input  logic                       presetn,
  input  logic                       psel,
  input  logic                       penable,
  input  logic                       pwrite,
  input  logic [rtr_pkg::ADDR_W-1:0] paddr,
  input  logic [rtr_pkg::DATA_W-1:0] pwdata,
  input  logic [3:0]                 pstrb,
  output logic                       pready,
  output logic [rtr_pkg::DATA_W-1:0] prdata,
  output logic                       pslverr,
  input  logic                       set_default,
  input  logic                       clear_strength,
  input  logic                       msg_start,
  input  logic                       adjust_valid,
  input  logic [rtr_pkg::CODE_W-1:0] adjust_code,
  input  logic                       strength_valid,
  input  logic [rtr_pkg::CODE_W-1:0] am_code,
  input  logic [rtr_pkg::CODE_W-1:0] pm_code,
  input  logic                       gpt_running,
  input  logic                       nrt_running,
  input  logic                       mrt_running,
  input  logic                       pm_channel_sel,
  output logic [rtr_pkg::CODE_W-1:0] reg_code,
  output logic                       reg_code_legal,
  output rtr_pkg::rtr_supply_t       supply_sel,
  output logic [3:0]                 supply_onehot,
  output logic [rtr_pkg::CODE_W-1:0] am_peak,
  output logic [rtr_pkg::CODE_W-1:0] pm_peak,
  output logic [rtr_pkg::CODE_W-1:0] logic_strength
);
  import rtr_pkg::*;

  logic [REG_W-1:0]  ctrl_q;
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] rd_d;
  logic              err_q;
  logic              err_d;
  logic [CODE_W-1:0] strength_q;
  logic              setup_ph;
  logic              access_ph;
  logic              ctrl_wr;
  logic              peak_clear;

  rtr_peak_if am_if ();
  rtr_peak_if pm_if ();

  // Bus phases

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;

  // Zero wait states: every access completes in its first access cycle
  assign pready  = access_ph;
  assign prdata  = rd_q;
  assign pslverr = access_ph && err_q;

  // Only byte lane 0 carries register bits
  assign ctrl_wr = access_ph && pwrite && (paddr == ADDR_CTRL) && pstrb[0];

  // Control register

  // The default command overrides a write landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (set_default) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[REG_W-1:0] & CTRL_WMASK;
    end
  end

  assign supply_sel    = rtr_supply_t'(ctrl_q[MEASURED_SUPPLY_SEL_HI:MEASURED_SUPPLY_SEL_LO]);
  assign supply_onehot = rtr_supply_onehot(supply_sel);

  // Regulator code in effect

  rtr_reg_sel u_reg_sel (
    .pclk         (pclk),
    .presetn      (presetn),
    .set_default  (set_default),
    .manual_mode  (ctrl_q[CTRL_MODE_BIT]),
    .manual_code  (ctrl_q[CTRL_CODE_HI:CTRL_CODE_LO]),
    .adjust_valid (adjust_valid),
    .adjust_code  (adjust_code),
    .eff_code     (reg_code),
    .code_legal   (reg_code_legal)
  );

  // Peak strength channels

  // Default, clear command and message start all restart both peaks
  assign peak_clear = set_default || clear_strength || msg_start;

  assign am_if.clear = peak_clear;
  assign am_if.valid = strength_valid;
  assign am_if.code  = am_code;
  assign pm_if.clear = peak_clear;
  assign pm_if.valid = strength_valid;
  assign pm_if.code  = pm_code;

  rtr_peak_hold u_am_peak (
    .pclk    (pclk),
    .presetn (presetn),
    .pk      (am_if.hold)
  );

  rtr_peak_hold u_pm_peak (
    .pclk    (pclk),
    .presetn (presetn),
    .pk      (pm_if.hold)
  );

  assign am_peak = am_if.peak;
  assign pm_peak = pm_if.peak;

  // Strength value the rest of the receiver acts on follows the chosen channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strength_q <= STR_RESET;
    end else begin
      strength_q <= pm_channel_sel ? pm_if.peak : am_if.peak;
    end
  end

  assign logic_strength = strength_q;

  // Read path

  always_comb begin
    rd_d  = '0;
    err_d = 1'b0;
    case (paddr)
      ADDR_CTRL: begin
        rd_d[REG_W-1:0] = ctrl_q & CTRL_WMASK;
      end
      ADDR_DISP: begin
        rd_d[DISP_CODE_HI:DISP_CODE_LO] = reg_code;
        rd_d[DISP_GPT_BIT]              = gpt_running;
        rd_d[DISP_NRT_BIT]              = nrt_running;
        rd_d[DISP_MRT_BIT]              = mrt_running;
      end
      ADDR_STR: begin
        rd_d[AM_PEAK_STRENGTH_MSB -: CODE_W] = am_if.peak;
        rd_d[PM_PEAK_STRENGTH_MSB -: CODE_W] = pm_if.peak;
      end
      ADDR_AUX: begin
        rd_d[AUX_CHAN_BIT] = pm_channel_sel;
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // Read data is sampled in the setup cycle and held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= '0;
    end else if (setup_ph) begin
      rd_q <= pwrite ? '0 : rd_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (setup_ph) begin
      err_q <= err_d;
    end
  end

  // Checks

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  sequence s_setup(logic [ADDR_W-1:0] a);
    psel && !penable && !pwrite && (paddr == a);
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_read_disp;
    s_setup(ADDR_DISP) ##1 s_access |->
      (prdata[DISP_CODE_HI:DISP_CODE_LO] == $past(reg_code)) &&
      (prdata[DISP_GPT_BIT] == $past(gpt_running)) &&
      (prdata[DISP_NRT_BIT] == $past(nrt_running)) &&
      (prdata[DISP_MRT_BIT] == $past(mrt_running)) &&
      (prdata[3] == 1'b0);
  endproperty

  property p_read_str;
    s_setup(ADDR_STR) ##1 s_access |->
      (prdata[AM_PEAK_STRENGTH_MSB -: CODE_W] == $past(am_peak)) &&
      (prdata[PM_PEAK_STRENGTH_MSB -: CODE_W] == $past(pm_peak));
  endproperty

  chk_manual_code_path: assert property (
    (ctrl_q[CTRL_MODE_BIT] && !set_default) |=> (reg_code == $past(ctrl_q[CTRL_CODE_HI:CTRL_CODE_LO])))
    else $error("written code not in effect");

  chk_ctrl_write_lands: assert property (
    (ctrl_wr && !set_default) |=> (ctrl_q == ($past(pwdata[REG_W-1:0]) & CTRL_WMASK)))
    else $error("control write lost");

  chk_supply_decode: assert property (
    (ctrl_wr && !set_default && pwdata[2:1] == 2'h3) |=> (supply_onehot == 4'h8))
    else $error("RF supply not selected");

  chk_ctrl_default: assert property (
    set_default |=> (ctrl_q == CTRL_RESET) && (supply_sel == SUP_MAIN))
    else $error("control not defaulted");

  chk_default_max_code: assert property (
    set_default |=> (reg_code == REG_CODE_MAX) ##1 (reg_code == REG_CODE_MAX) || set_default)
    else $error("default code is not maximum");

  chk_disp_read_back: assert property (p_read_disp)
    else $error("display readback wrong");

  chk_str_read_back: assert property (p_read_str)
    else $error("strength readback wrong");

  chk_str_default: assert property (
    (set_default && !strength_valid) |=> (am_peak == STR_RESET) && (pm_peak == STR_RESET))
    else $error("strength not cleared on default");

  chk_chan_bit_read: assert property (
    s_setup(ADDR_AUX) |=> (prdata[AUX_CHAN_BIT] == $past(pm_channel_sel)) && (prdata[6:0] == 7'h00))
    else $error("channel bit wrong");

  chk_logic_strength_sel: assert property (
    pm_channel_sel |=> (logic_strength == $past(pm_peak)))
    else $error("internal strength not PM");

  chk_ro_write_ignored: assert property (
    (access_ph && pwrite && (paddr != ADDR_CTRL) && !set_default) |=> $stable(ctrl_q))
    else $error("write outside control changed it");

  chk_rsvd_zero: assert property (
    s_setup(ADDR_CTRL) |=> (prdata[0] == 1'b0) && (prdata[DATA_W-1:REG_W] == '0))
    else $error("unused bits not zero");

  chk_unmapped_err: assert property (
    (setup_ph && (paddr != ADDR_CTRL) && (paddr != ADDR_DISP) && (paddr != ADDR_STR) &&
     (paddr != ADDR_AUX)) ##1 access_ph |-> pslverr && (prdata == '0))
    else $error("unmapped access not refused");

endmodule // rtr_regs

//--- verif/rtr_afe_model.sv
// Front-end model driving adjust, strength, timer, channel and command inputs of the bank
`timescale 1ns/1ns
module rtr_afe_model (
  input  logic       pclk,
  output logic       set_default,
  output logic       clear_strength,
  output logic       msg_start,
  output logic       adjust_valid,
  output logic [3:0] adjust_code,
  output logic       strength_valid,
  output logic [3:0] am_code,
  output logic [3:0] pm_code,
  output logic       gpt_running,
  output logic       nrt_running,
  output logic       mrt_running,
  output logic       pm_channel_sel
);
  initial begin
    {set_default, clear_strength, msg_start, adjust_valid, strength_valid} = 5'h00;
    {adjust_code, am_code, pm_code} = 12'h000;
    {gpt_running, nrt_running, mrt_running, pm_channel_sel} = 4'h0;
  end

  // One-cycle pulse: 0 adjust, 1 strength, 2 message start, 3 clear, 4 set default
  task automatic pulse(input int kind, input logic [3:0] a, input logic [3:0] p);
    @(posedge pclk);
    case (kind)
      0: begin
        adjust_valid <= 1'h1;
        adjust_code  <= a;
      end
      1: begin
        strength_valid <= 1'h1;
        am_code        <= a;
        pm_code        <= p;
      end
      2: msg_start <= 1'h1;
      3: clear_strength <= 1'h1;
      default: set_default <= 1'h1;
    endcase
    @(posedge pclk);
    {set_default, clear_strength, msg_start, adjust_valid, strength_valid} <= 5'h00;
    // Codes are not held once valid drops, so the bank must not rely on them
    adjust_code <= ~a;
    am_code     <= ~a;
    pm_code     <= ~p;
  endtask

  task automatic levels(input logic [2:0] t, input logic ch);
    @(posedge pclk);
    {gpt_running, nrt_running, mrt_running} <= t;
    pm_channel_sel <= ch;
  endtask
endmodule // rtr_afe_model

//--- verif/rtr_regs_tb.sv
// Self-checking bench for the regulator, timer and strength register bank
`timescale 1ns/1ns
module rtr_regs_tb;
  import rtr_pkg::*;
  logic              pclk    = 1'h0;
  logic              presetn = 1'h0;
  logic              psel    = 1'h0;
  logic              penable = 1'h0;
  logic              pwrite  = 1'h0;
  logic [ADDR_W-1:0] paddr   = 8'h00;
  logic [DATA_W-1:0] pwdata  = 32'h0;
  logic [3:0]        pstrb   = 4'h1;
  logic              pready, pslverr, reg_code_legal, err;
  logic [DATA_W-1:0] prdata, rd;
  logic              set_default, clear_strength, msg_start, adjust_valid, strength_valid;
  logic              gpt_running, nrt_running, mrt_running, pm_channel_sel;
  logic [CODE_W-1:0] adjust_code, am_code, pm_code, reg_code, am_peak, pm_peak, logic_strength;
  logic [3:0]        supply_onehot;
  rtr_supply_t       supply_sel;
  logic [3:0]        c;
  int                n_mismatch = 0;
  int                tests_run  = 0;

  always #5 pclk = ~pclk;

  rtr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .set_default(set_default), .clear_strength(clear_strength), .msg_start(msg_start),
    .adjust_valid(adjust_valid), .adjust_code(adjust_code), .strength_valid(strength_valid),
    .am_code(am_code), .pm_code(pm_code), .gpt_running(gpt_running), .nrt_running(nrt_running),
    .mrt_running(mrt_running), .pm_channel_sel(pm_channel_sel), .reg_code(reg_code),
    .reg_code_legal(reg_code_legal), .supply_sel(supply_sel), .supply_onehot(supply_onehot),
    .am_peak(am_peak), .pm_peak(pm_peak), .logic_strength(logic_strength));

  rtr_afe_model afe_u (.pclk(pclk), .set_default(set_default), .clear_strength(clear_strength),
    .msg_start(msg_start), .adjust_valid(adjust_valid), .adjust_code(adjust_code),
    .strength_valid(strength_valid), .am_code(am_code), .pm_code(pm_code), .gpt_running(gpt_running),
    .nrt_running(nrt_running), .mrt_running(mrt_running), .pm_channel_sel(pm_channel_sel));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits on pready with no bound of its own; only the watchdog ends a hung access
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'h0, a, 8'h00, 4'h1);
    chk(rd, exp);
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_DISP, 32'hf0);
    rdchk(ADDR_STR, 32'h0);
    // Every supply select, each with a different written code; bit 0 written high
    for (int s = 0; s < 4; s++) begin
      c = 4'(5 + 3 * s);
      apb(1'h1, ADDR_CTRL, {1'h1, c, 2'(s), 1'h1}, 4'h1);
      rdchk(ADDR_CTRL, {24'h0, 1'h1, c, 2'(s), 1'h0});
      rdchk(ADDR_DISP, {24'h0, c, 4'h0});
      chk(supply_sel, 32'(s));
      chk(supply_onehot, 32'h1 << s);
      chk(reg_code_legal, 32'h1);
    end
    apb(1'h1, ADDR_CTRL, 8'ha0, 4'h1);
    rdchk(ADDR_DISP, 32'h40);
    chk(reg_code_legal, 32'h0);
    // Back to adjust mode: the adjust result takes over
    apb(1'h1, ADDR_CTRL, 8'h00, 4'h1);
    afe_u.pulse(0, 4'h9, 4'h0);
    repeat (2) @(posedge pclk);
    chk(reg_code, 32'h9);
    apb(1'h1, ADDR_CTRL, 8'hfe, 4'h0);
    rdchk(ADDR_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      afe_u.levels(3'(1 << i), 1'h0);
      rdchk(ADDR_DISP, 32'h90 | (32'h1 << i));
    end
    afe_u.levels(3'h0, 1'h0);
    afe_u.pulse(1, 4'h3, 4'h7);
    afe_u.pulse(1, 4'h2, 4'h9);
    afe_u.pulse(1, 4'h1, 4'h4);
    rdchk(ADDR_STR, 32'h39);
    chk(am_peak, 32'h3);
    chk(pm_peak, 32'h9);
    afe_u.levels(3'h0, 1'h1);
    repeat (2) @(posedge pclk);
    chk(logic_strength, 32'h9);
    rdchk(ADDR_AUX, 32'h80);
    afe_u.levels(3'h0, 1'h0);
    rdchk(ADDR_AUX, 32'h0);
    chk(logic_strength, 32'h3);
    // Read-only places keep their content when written
    apb(1'h1, ADDR_STR, 8'hff, 4'h1);
    rdchk(ADDR_STR, 32'h39);
    apb(1'h1, ADDR_DISP, 8'hff, 4'h1);
    rdchk(ADDR_DISP, 32'h90);
    apb(1'h0, 8'h04, 8'h00, 4'h1);
    chk({err, rd[30:0]}, 32'h80000000);
    afe_u.pulse(2, 4'h0, 4'h0);
    rdchk(ADDR_STR, 32'h0);
    afe_u.pulse(1, 4'h5, 4'h6);
    afe_u.pulse(3, 4'h0, 4'h0);
    rdchk(ADDR_STR, 32'h0);
    apb(1'h1, ADDR_CTRL, 8'hb6, 4'h1);
    afe_u.pulse(1, 4'hc, 4'ha);
    afe_u.pulse(4, 4'h0, 4'h0);
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_DISP, 32'hf0);
    rdchk(ADDR_STR, 32'h0);
    final_report();
  end
endmodule // rtr_regs_tb
